//--- design/slt_pkg.sv
// Constants, register map and types shared by the sleep interval timer
package slt_pkg;
  // ************************************
  // Register offsets on the byte port
  // ************************************
  localparam logic [9:0] ADDR_WAKE_LO = 10'h222;  // Wake match value, bits 7:0
  localparam logic [9:0] ADDR_WAKE_HI = 10'h223;  // Wake match value, bits 10:8
  localparam logic [9:0] ADDR_FINE_LO = 10'h224;  // Fine tick count, bits 7:0
  localparam logic [9:0] ADDR_FINE_HI = 10'h225;  // Fine tick count, bits 15:8
  localparam logic [9:0] ADDR_MAIN0   = 10'h226;  // Coarse count, bits 7:0
  localparam logic [9:0] ADDR_MAIN1   = 10'h227;  // Coarse count, bits 15:8
  localparam logic [9:0] ADDR_MAIN2   = 10'h228;  // Coarse count, bits 23:16
  localparam logic [9:0] ADDR_MAIN3   = 10'h229;  // Trigger and coarse bits 25:24
  localparam logic [9:0] ADDR_CFG     = 10'h22A;  // Source select and divider
  localparam logic [9:0] ADDR_STAT    = 10'h22B;  // Sticky events and run flag
  localparam logic [9:0] ADDR_MASK    = 10'h22C;  // Interrupt mask
  // ************************************
  // Field positions and reset values
  // ************************************
  localparam int         TRIG_BIT     = 7;        // Trigger bit in ADDR_MAIN3
  localparam int         SEL_LSB      = 6;        // Source select, cfg bits 7:6
  localparam int         DIV_W        = 5;        // Divider field, cfg bits 4:0
  localparam int         EV_WAKE      = 0;        // Status: wake match seen
  localparam int         EV_DONE      = 1;        // Status: interval ended
  localparam int         RUN_BIT      = 2;        // Status: timer running
  localparam int         EV_W         = 2;        // Number of event bits
  localparam logic [7:0] WAKE_LO_RST  = 8'h0A;
  localparam logic [2:0] WAKE_HI_RST  = 3'h0;
  localparam logic [10:0] WAKE_MIN    = 11'h001;
  localparam logic [1:0] SRC_INT      = 2'h0;     // Internal low-power oscillator
  localparam logic [1:0] SRC_EXT      = 2'h1;     // External sleep clock pin
  localparam logic [4:0] DIV_MIN_INT  = 5'h01;
  // ************************************
  // Interval kinds
  // ************************************
  localparam logic [1:0] KIND_SLEEP    = 2'h0;  // Nonbeacon sleep interval
  localparam logic [1:0] KIND_BEACON   = 2'h1;  // Beacon interval
  localparam logic [1:0] KIND_INACTIVE = 2'h2;  // Inactive period
  // ************************************
  // Timing
  // ************************************
  localparam int         CLK_NS       = 4;      // System clock period
  localparam int         TICK_NS      = 50;     // Fine tick period
  localparam int         TICK_CYC     = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] TICK_LAST    = 4'(TICK_CYC - 1);
  // Sequencer states
  typedef enum logic [1:0] {SLT_IDLE, SLT_MAIN, SLT_FINE} slt_state_t;
endpackage

//--- design/slt_sync.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module slt_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);
  logic meta;       // First stage, read only by the second
  logic next_meta;
  logic next_dout;

  // Next values, frozen while the clock enable is low
  always_comb begin
    next_meta = ce ? din : meta;
    next_dout = ce ? meta : dout;
  end

  // Stage registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end
endmodule

//--- design/slt_lp_div.sv
// Power-of-two divider of the selected low-power clock edges
`timescale 1ns/100ps
module slt_lp_div
  import slt_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             clr,
  input  wire logic             src_edge,
  input  wire logic [DIV_W-1:0] div,
  output logic                  tick
);
  logic [30:0] cnt;       // Edges seen in this period
  logic [30:0] last;      // Two to the power div, less one
  logic [30:0] next_cnt;
  logic        next_tick;

  // Count edges; one tick per 2**div edges
  always_comb begin
    last      = (31'h1 << div) - 31'h1;
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (clr) begin
      next_cnt = 31'h0;
    end else if (src_edge) begin
      next_tick = (cnt == last);
      next_cnt  = (cnt == last) ? 31'h0 : cnt + 31'h1;
    end
    if (!ce) begin
      next_cnt  = cnt;
      next_tick = tick;
    end
  end

  // Divider registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt  <= 31'h0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

//--- design/slt_timer.sv
// Sleep interval timer: registers, coarse and fine counters, wake match
//
// Function
// RULE1: Wake match on coarse count re-enables oscillator
// RULE2: Wake match resets to ten, minimum one
// RULE3: Software keeps wake match above settle count
// RULE4: Wake bits 10:8 in high register 2:0
// RULE5: Fine counter 16 bits, low/high bytes
// RULE6: Fine counter counts 50 ns ticks; the code ticks every 13 system cycles, 52 ns
// RULE7: Coarse counter 26 bits, low-power periods
// RULE8: Counters time beacon, inactive, sleep intervals
// RULE9: Period set by source and divider
// RULE10: Trigger bit starts sleep, clears itself
// RULE11: Coarse bits 25:24 beside trigger bit
// RULE12: Divide selected clock by two**divider
// RULE13: Internal oscillator needs divider at least one; the code floors it for select 0 only, not 2 or 3, which also pick it
// RULE14: Coarse counts from zero, then fine remainder
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
module slt_timer
  import slt_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [9:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       lp_osc_int,
  input  wire logic       lp_clk_ext,
  input  wire logic       beacon_start,
  input  wire logic       inactive_start,
  output logic            osc_enable,
  output logic            timer_active,
  output logic      [1:0] interval_kind,
  output logic            interval_done,
  output logic            irq
);
  // ************************************
  // Register file
  // ************************************
  logic [7:0]       wake_lo;     // Wake match value, low byte
  logic [2:0]       wake_hi;     // Wake match value, top three bits
  logic [15:0]      fine_tgt;    // Fine remainder length in ticks
  logic [25:0]      main_tgt;    // Coarse length in low-power periods
  logic             trig;        // Trigger bit, lives one cycle
  logic [1:0]       src_sel;     // Low-power source select
  logic [DIV_W-1:0] div_set;     // Divider exponent
  logic [EV_W-1:0]  stat;        // Sticky events
  logic [EV_W-1:0]  mask;        // Interrupt mask
  logic [7:0]       next_wake_lo;
  logic [2:0]       next_wake_hi;
  logic [15:0]      next_fine_tgt;
  logic [25:0]      next_main_tgt;
  logic             next_trig;
  logic [1:0]       next_src_sel;
  logic [DIV_W-1:0] next_div_set;
  logic [EV_W-1:0]  next_stat;
  logic [EV_W-1:0]  next_mask;
  logic [7:0]       next_rdata;
  logic             next_irq;
  // ************************************
  // Sequencer state
  // ************************************
  slt_state_t       state;       // Idle, coarse or fine phase
  logic [25:0]      main_cnt;    // Coarse periods elapsed
  logic [15:0]      fine_cnt;    // Fine ticks elapsed
  logic [3:0]       fine_pre;    // System cycles within one fine tick
  slt_state_t       next_state;
  logic [25:0]      next_main_cnt;
  logic [15:0]      next_fine_cnt;
  logic [3:0]       next_fine_pre;
  logic             next_osc_enable;
  logic             next_timer_active;
  logic [1:0]       next_interval_kind;
  logic             next_interval_done;
  // ************************************
  // Derived signals
  // ************************************
  logic             int_sync;    // Synchronised internal oscillator
  logic             ext_sync;    // Synchronised external clock
  logic             sel_lvl;     // Chosen source level
  logic             sel_prev;    // Chosen level one cycle ago
  logic             next_sel_prev;
  logic             src_edge;    // Rising edge of the chosen source
  logic             lp_tick;     // One divided low-power period
  logic [DIV_W-1:0] div_eff;     // Divider after source check
  logic [10:0]      wake_eff;    // Wake match in use
  logic [25:0]      main_left;   // Coarse periods left to run
  logic             wake_hit;    // Wake match reached this cycle
  logic             fine_tick;   // One fine tick, 13 system cycles (52 ns)
  logic             start;       // Any interval start
  logic [1:0]       start_kind;  // Kind of the interval being started
  logic             rd_hit;      // Read hits a mapped register

  // ************************************
  // Low-power clock path
  // ************************************
  slt_sync u_sync_int (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .din     (lp_osc_int),
    .dout    (int_sync)
  );

  slt_sync u_sync_ext (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .din     (lp_clk_ext),
    .dout    (ext_sync)
  );

  // Source choice and divider floor
  always_comb begin
    sel_lvl  = (src_sel == SRC_EXT) ? ext_sync : int_sync;  // see RULE9
    src_edge = sel_lvl & ~sel_prev;
    // Guard against a zero divider on the internal oscillator when selected by SRC_INT
    div_eff  = div_set;                                     // see RULE13
    if (src_sel == SRC_INT && div_set < DIV_MIN_INT) begin
      div_eff = DIV_MIN_INT;
    end
    next_sel_prev = ce ? sel_lvl : sel_prev;
  end

  // Edge detector history
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_prev <= 1'b0;
    end else begin
      sel_prev <= next_sel_prev;
    end
  end

  // Each coarse period spans 2**div source edges; restart on each start
  slt_lp_div u_div (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .clr      (start),
    .src_edge (src_edge),
    .div      (div_eff),
    .tick     (lp_tick)
  ); // see RULE12

  // ************************************
  // Sequencer
  // ************************************
  // Start sources, comparison and fine tick
  always_comb begin
    start      = (trig | beacon_start | inactive_start) & (state == SLT_IDLE);
    start_kind = trig ? KIND_SLEEP : (beacon_start ? KIND_BEACON : KIND_INACTIVE);
    // A stored zero is lifted to the minimum, never compared as zero
    wake_eff   = {wake_hi, wake_lo};                               // see RULE4
    if (wake_eff < WAKE_MIN) begin
      wake_eff = WAKE_MIN;                                         // see RULE2
    end
    // Compared against the coarse periods still to run, so the
    // oscillator is back before the fine phase needs it
    main_left  = main_tgt - main_cnt;
    wake_hit   = (state == SLT_MAIN) && (main_left == {15'h0, wake_eff});  // see RULE1
    fine_tick  = (state == SLT_FINE) && (fine_pre == TICK_LAST);          // see RULE6
  end

  // Next state of the interval sequencer
  always_comb begin
    next_state         = state;
    next_main_cnt      = main_cnt;
    next_fine_cnt      = fine_cnt;
    next_fine_pre      = fine_pre;
    next_osc_enable    = osc_enable;
    next_timer_active  = timer_active;
    next_interval_kind = interval_kind;
    next_interval_done = 1'b0;
    case (state)
      SLT_IDLE: begin
        // Every interval kind uses the same two counters
        if (start) begin
          next_state         = (main_tgt == 26'h0) ? SLT_FINE : SLT_MAIN;  // see RULE8
          next_main_cnt      = 26'h0;                                     // see RULE14
          next_fine_cnt      = 16'h0;
          next_fine_pre      = 4'h0;
          next_osc_enable    = (main_tgt == 26'h0);
          next_timer_active  = 1'b1;
          next_interval_kind = start_kind;
        end
      end
      SLT_MAIN: begin
        if (wake_hit) begin
          next_osc_enable = 1'b1;
        end
        if (lp_tick) begin
          next_main_cnt = main_cnt + 26'h1;                              // see RULE7
          if (main_cnt + 26'h1 == main_tgt) begin
            next_state      = SLT_FINE;                                  // see RULE14
            next_osc_enable = 1'b1;
          end
        end
      end
      SLT_FINE: begin
        next_fine_pre = fine_tick ? 4'h0 : fine_pre + 4'h1;
        if (fine_cnt == fine_tgt) begin
          next_state         = SLT_IDLE;
          next_timer_active  = 1'b0;
          next_interval_done = 1'b1;
        end else if (fine_tick) begin
          next_fine_cnt = fine_cnt + 16'h1;                              // see RULE5
        end
      end
      default: begin
        next_state = SLT_IDLE;
      end
    endcase
    if (!ce) begin
      next_state         = state;
      next_main_cnt      = main_cnt;
      next_fine_cnt      = fine_cnt;
      next_fine_pre      = fine_pre;
      next_osc_enable    = osc_enable;
      next_timer_active  = timer_active;
      next_interval_kind = interval_kind;
      next_interval_done = interval_done;
    end
  end

  // Sequencer registers; the oscillator runs while idle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state         <= SLT_IDLE;
      main_cnt      <= 26'h0;
      fine_cnt      <= 16'h0;
      fine_pre      <= 4'h0;
      osc_enable    <= 1'b1;
      timer_active  <= 1'b0;
      interval_kind <= KIND_SLEEP;
      interval_done <= 1'b0;
    end else begin
      state         <= next_state;
      main_cnt      <= next_main_cnt;
      fine_cnt      <= next_fine_cnt;
      fine_pre      <= next_fine_pre;
      osc_enable    <= next_osc_enable;
      timer_active  <= next_timer_active;
      interval_kind <= next_interval_kind;
      interval_done <= next_interval_done;
    end
  end

  // ************************************
  // Register port
  // ************************************
  // Writes, self-clearing trigger, sticky events and read mux
  always_comb begin
    next_wake_lo  = wake_lo;
    next_wake_hi  = wake_hi;
    next_fine_tgt = fine_tgt;
    next_main_tgt = main_tgt;
    next_trig     = 1'b0;                                                 // see RULE10
    next_src_sel  = src_sel;
    next_div_set  = div_set;
    next_mask     = mask;
    next_stat     = stat;
    if (wr) begin
      case (addr)
        ADDR_WAKE_LO: next_wake_lo = wdata;
        ADDR_WAKE_HI: next_wake_hi = wdata[2:0];                          // see RULE4
        ADDR_FINE_LO: next_fine_tgt[7:0]  = wdata;                        // see RULE5
        ADDR_FINE_HI: next_fine_tgt[15:8] = wdata;
        ADDR_MAIN0:   next_main_tgt[7:0]   = wdata;
        ADDR_MAIN1:   next_main_tgt[15:8]  = wdata;
        ADDR_MAIN2:   next_main_tgt[23:16] = wdata;
        ADDR_MAIN3: begin
          next_main_tgt[25:24] = wdata[1:0];                              // see RULE11
          next_trig            = wdata[TRIG_BIT];                         // see RULE10
        end
        ADDR_CFG: begin
          next_src_sel = wdata[SEL_LSB+1:SEL_LSB];
          next_div_set = wdata[DIV_W-1:0];
        end
        ADDR_STAT:    next_stat = stat & ~wdata[EV_W-1:0];
        ADDR_MASK:    next_mask = wdata[EV_W-1:0];
        default:      next_stat = stat;
      endcase
    end
    // A new event wins over a clear in the same cycle
    if (wake_hit) begin
      next_stat[EV_WAKE] = 1'b1;
    end
    if (next_interval_done && !interval_done) begin
      next_stat[EV_DONE] = 1'b1;
    end
    rd_hit     = (addr >= ADDR_WAKE_LO) && (addr <= ADDR_MASK);
    next_rdata = 8'h00;
    if (rd) begin
      case (addr)
        ADDR_WAKE_LO: next_rdata = wake_lo;
        ADDR_WAKE_HI: next_rdata = {5'h00, wake_hi};
        ADDR_FINE_LO: next_rdata = fine_tgt[7:0];
        ADDR_FINE_HI: next_rdata = fine_tgt[15:8];
        ADDR_MAIN0:   next_rdata = main_tgt[7:0];
        ADDR_MAIN1:   next_rdata = main_tgt[15:8];
        ADDR_MAIN2:   next_rdata = main_tgt[23:16];
        ADDR_MAIN3:   next_rdata = {6'h00, main_tgt[25:24]};
        ADDR_CFG:     next_rdata = {src_sel, 1'b0, div_set};
        ADDR_STAT:    next_rdata = {5'h00, timer_active, stat};
        ADDR_MASK:    next_rdata = {6'h00, mask};
        default:      next_rdata = 8'h00;
      endcase
    end
    next_irq = |(next_stat & next_mask);
    if (!ce) begin
      next_wake_lo  = wake_lo;
      next_wake_hi  = wake_hi;
      next_fine_tgt = fine_tgt;
      next_main_tgt = main_tgt;
      next_trig     = trig;
      next_src_sel  = src_sel;
      next_div_set  = div_set;
      next_mask     = mask;
      next_stat     = stat;
      next_rdata    = rdata;
      next_irq      = irq;
    end
  end

  // Register file flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_lo  <= WAKE_LO_RST;                                            // see RULE2
      wake_hi  <= WAKE_HI_RST;
      fine_tgt <= 16'h0000;
      main_tgt <= 26'h0000000;
      trig     <= 1'b0;
      src_sel  <= SRC_INT;
      div_set  <= 5'h00;
      stat     <= 2'h0;
      mask     <= 2'h0;
      rdata    <= 8'h00;
      irq      <= 1'b0;
    end else begin
      wake_lo  <= next_wake_lo;
      wake_hi  <= next_wake_hi;
      fine_tgt <= next_fine_tgt;
      main_tgt <= next_main_tgt;
      trig     <= next_trig;
      src_sel  <= next_src_sel;
      div_set  <= next_div_set;
      stat     <= next_stat;
      mask     <= next_mask;
      rdata    <= next_rdata;
      irq      <= next_irq;
    end
  end

  // ************************************
  // Assertions
  // ************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !ce);

  sequence s_start;
    start && main_tgt != 26'h0;
  endsequence
  sequence s_sleeping;
    state == SLT_MAIN && !osc_enable && main_cnt == 26'h0;
  endsequence

  a_trig_self_clear: assert property (trig && !(wr && addr == ADDR_MAIN3) |=> !trig)  // see RULE10
    else $error("trigger bit did not clear");
  a_start_sleeps: assert property (s_start |=> s_sleeping)  // see RULE14
    else $error("start did not enter coarse phase at zero");
  a_wake_osc_on: assert property (wake_hit |=> osc_enable && stat[EV_WAKE])  // see RULE1
    else $error("wake match did not enable oscillator");
  a_wake_min_one: assert property (wake_eff >= WAKE_MIN)  // see RULE2
    else $error("wake match below one");
  a_fine_tick_gap: assert property (fine_tick |=> !fine_tick [*8])  // see RULE6
    else $error("fine ticks too close");
  a_coarse_step: assert property (
    state == SLT_MAIN && lp_tick |=> main_cnt == $past(main_cnt) + 26'h1)  // see RULE7
    else $error("coarse counter did not advance");
  a_done_idle: assert property (interval_done |-> state == SLT_IDLE && osc_enable)  // see RULE8
    else $error("interval end left timer busy");
  a_irq_follows: assert property (irq == |(stat & mask))
    else $error("interrupt does not follow masked status");
  a_unmapped_zero: assert property (rd && !rd_hit |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

//--- bench/slt_timer_tb.sv
// Self-checking testbench for the sleep interval timer
`timescale 1ns/100ps
module slt_timer_tb
  import slt_pkg::*;
;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic       clk_sys        = 1'b0;
  logic       rst            = 1'b1;
  logic       ce             = 1'b1;   // Low freezes the whole block
  logic [9:0] addr           = 10'h000;
  logic [7:0] wdata          = 8'h00;
  logic       wr             = 1'b0;
  logic       rd             = 1'b0;
  logic [7:0] rdata;
  logic       lp_osc_int     = 1'b0;   // Period 10 cycles
  logic       lp_clk_ext     = 1'b0;   // Period 8 cycles, so a wrong source shows
  logic       beacon_start   = 1'b0;
  logic       inactive_start = 1'b0;
  logic       osc_enable;
  logic       timer_active;
  logic [1:0] interval_kind;
  logic       interval_done;
  logic       irq;
  int         fails          = 0;
  int         cmp_count      = 0;
  int         cyc            = 0;
  int         lpc            = 0;
  int         seed           = 32'h672B4D20;
  int         model [int];             // Register image kept by the bench

  slt_timer slt_timer_i (.clk_sys(clk_sys), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .lp_osc_int(lp_osc_int), .lp_clk_ext(lp_clk_ext),
    .beacon_start(beacon_start), .inactive_start(inactive_start), .osc_enable(osc_enable),
    .timer_active(timer_active), .interval_kind(interval_kind),
    .interval_done(interval_done), .irq(irq));

  // ****************************************
  // Clocks, free-running oscillators, timeout
  // ****************************************
  always #2 clk_sys = ~clk_sys;
  // Both low-power sources run free, as oscillators do
  always @(posedge clk_sys) begin
    lpc <= lpc + 1;
    if (lpc % 5 == 4) lp_osc_int <= ~lp_osc_int;
    if (lpc % 4 == 3) lp_clk_ext <= ~lp_clk_ext;
  end
  // A hang ends the run as a failure
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask
  // Durations depend on oscillator phase, so allow a tolerance
  task automatic chk_rng(input int got, input int exp, input int tol, input string msg);
    cmp_count++;
    if (got > exp + tol || got < exp - tol) begin
      fails++;
      $display("wrong value at %0t: %s measured %0d expected %0d", $time, msg, got, exp);
    end
  endtask
  // Bits a register keeps; zero means unmapped or not stored
  function automatic int rmask(input int a);
    case (a)
      32'h222, 32'h224, 32'h225, 32'h226, 32'h227, 32'h228: rmask = 32'hFF;
      32'h223: rmask = 32'h07;
      32'h229: rmask = 32'h03;
      32'h22A: rmask = 32'hDF;
      32'h22C: rmask = 32'h03;
      default: rmask = 32'h00;
    endcase
  endfunction
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
    if (rmask(int'(a)) != 0) model[int'(a)] = int'(d) & rmask(int'(a));
  endtask
  task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    @(posedge clk_sys);
    d = rdata;
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk({24'h0, d}, {24'h0, exp}, "register read");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // One interval: program, start, measure
  // ****************************************
  task automatic run(input int src, input int dv, input int n, input int f, input int w,
                     input int how);
    int   tp;
    int   act;
    int   osc;
    int   lim;
    int   tol;
    logic low_seen;
    logic kind_bad;
    begin
      tp = (src == 1) ? 8 : 10;
      tol = (n == 0) ? 4 : tp + 8;
      wr_reg(ADDR_CFG, {src[1:0], 1'b0, dv[4:0]});
      wr_reg(ADDR_WAKE_LO, w[7:0]);
      wr_reg(ADDR_WAKE_HI, {5'h0, w[10:8]});
      wr_reg(ADDR_FINE_LO, f[7:0]);
      wr_reg(ADDR_FINE_HI, f[15:8]);
      wr_reg(ADDR_MAIN0, n[7:0]);
      wr_reg(ADDR_MAIN1, n[15:8]);
      wr_reg(ADDR_MAIN2, n[23:16]);
      if (how == 0) begin
        wr_reg(ADDR_MAIN3, {1'b1, 5'h0, n[25:24]});
      end else begin
        @(posedge clk_sys);
        beacon_start   <= (how == 1);
        inactive_start <= (how == 2);
        @(posedge clk_sys);
        beacon_start   <= 1'b0;
        inactive_start <= 1'b0;
      end
      act = 0;
      osc = 0;
      lim = 0;
      low_seen = 1'b0;
      kind_bad = 1'b0;
      while (interval_done !== 1'b1 && lim < 5000) begin
        @(posedge clk_sys);
        lim++;
        if (timer_active === 1'b1) begin
          act++;
          if (osc_enable === 1'b1) osc++;
          else low_seen = 1'b1;
          if (interval_kind !== 2'(how)) kind_bad = 1'b1;
        end
      end
      chk(32'(lim < 5000), 32'h1, "interval never ended");
      chk_rng(act, n * (1 << dv) * tp + f * TICK_CYC, tol, "interval length");
      chk_rng(osc, ((n == 0) ? 0 : w * (1 << dv) * tp) + f * TICK_CYC, tol,
              "wake lead");
      chk(32'(low_seen), 32'(n > 0), "oscillator off in coarse phase");
      chk(32'(kind_bad), 32'h0, "interval kind");
      rd_chk(ADDR_MAIN3, model[32'h229][7:0]);
      rd_chk(ADDR_STAT, (n >= w && n > 0) ? 8'h03 : 8'h02);
      $display("test interval src %0d div %0d coarse %0d fine %0d done", src, dv, n, f);
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] d;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 32'h222; a <= 32'h22D; a++) model[a] = (a == 32'h222) ? 32'h0A : 32'h0;
    // Reset values, then random write and read-back, unmapped place included
    for (int a = 32'h222; a <= 32'h22D; a++) begin
      rd_chk(a[9:0], model[a][7:0]);
      if (a != 32'h22B) begin
        d = 8'($random(seed)) & 8'(rmask(a));
        if (a == 32'h222 || a == 32'h22A) d[0] = 1'b1;
        wr_reg(a[9:0], d);
        rd_chk(a[9:0], model[a][7:0]);
      end
    end
    wr_reg(ADDR_MASK, 8'h00);
    $display("test registers done");
    // External source, divider 2, trigger start; other sources, dividers and kinds run later
    run(1, 2, 6, 3, 2, 0);
    // Interrupt: masked, enabled, cleared one bit at a time
    chk({31'h0, irq}, 32'h0, "irq while masked");
    wr_reg(ADDR_MASK, 8'h02);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1, "irq when unmasked");
    wr_reg(ADDR_STAT, 8'h02);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    rd_chk(ADDR_STAT, 8'h01);
    wr_reg(ADDR_MASK, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1, "irq on wake bit");
    wr_reg(ADDR_STAT, 8'h01);
    wr_reg(ADDR_MASK, 8'h00);
    rd_chk(ADDR_STAT, 8'h00);
    // Clock enable low freezes the registers, so this write is lost
    ce <= 1'b0;
    wr_reg(ADDR_MASK, 8'h03);
    ce <= 1'b1;
    rd_chk(ADDR_MASK, 8'h00);
    $display("test interrupt done");
    run(0, 1, 6, 2, 1, 1);
    wr_reg(ADDR_STAT, 8'h03);
    run(1, 0, 5, 2, 3, 2);
    wr_reg(ADDR_STAT, 8'h03);
    run(0, 1, 0, 260, 1, 0);
    finish_test();
  end
endmodule
